// ==== src/cto_pkg.sv ====
package cto_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_IRQCFG  = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_MASK    = 8'h0c;
  localparam logic [7:0] OFS_CAMST   = 8'h10;
  localparam logic [7:0] OFS_OFFSET  = 8'h14;
  localparam logic [7:0] OFS_START0  = 8'h20;
  localparam logic [7:0] OFS_END0    = 8'h40;
  localparam logic [7:0] OFS_TBL_TOP = 8'h5c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_TDYN_LSB   = 0;
  localparam int CTRL_DMODE_LSB  = 16;
  localparam int CTRL_CTYPE_LSB  = 24;
  localparam int IRQ_SEL1_LSB    = 0;
  localparam int IRQ_EDGE1_BIT   = 4;
  localparam int IRQ_SEL2_LSB    = 8;
  localparam int IRQ_EDGE2_BIT   = 12;
  localparam int IRQ_TOFF_BIT    = 16;
  localparam int ST_PI1          = 0;
  localparam int ST_PI2          = 1;
  localparam int ST_TOFF         = 2;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int         NCAMS      = 8;
  localparam int         NTCAMS     = 2;
  localparam logic [3:0] SEL_MAX    = 4'h8;
  localparam logic [15:0] TDYN_RST  = 16'h0000;

  typedef enum logic [1:0] {
    CTO_DIR_BOTH = 2'h0,
    CTO_DIR_FWD  = 2'h1,
    CTO_DIR_REV  = 2'h2
  } cto_dir_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 40;
  localparam int MS_NS          = 1000000;
  localparam int MS_CYCLES_DEF  = MS_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  RECALC_MS  = 8'h80;
  localparam logic [16:0] TCAM_MIN_MS  = 17'h00018;
  localparam logic [16:0] TCAM_MAX_MS  = 17'h0fffc;
  localparam logic [16:0] TCAM_STEP_M1 = 17'h00007;

  // ----------------------------------------------------------------
  // Whole state of the track
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0]        tdyn;
    logic [1:0]         dmode;
    logic [1:0]         ctype;
    logic [3:0]         sel1;
    logic               edge1;
    logic [3:0]         sel2;
    logic               edge2;
    logic               toff_en;
    logic [2:0]         sts;
    logic [2:0]         msk;
    logic [7:0][31:0]   cstart;
    logic [7:0][31:0]   cend;
    logic [31:0]        offs;
    logic [31:0]        spd_used;
    logic [15:0]        tick;
    logic [7:0]         ms_cnt;
    logic [7:0]         cam;
    logic [1:0][16:0]   tleft;
    logic [1:0]         ge_prev;
    logic               pi1;
    logic               pi2;
    logic               irq;
    logic               pready;
    logic [31:0]        prdata;
    logic               pslverr;
  } cto_state_t;

endpackage

// ==== src/cto_track.sv ====
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps

module cto_track #(
  parameter int unsigned MS_CYCLES = cto_pkg::MS_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Axis measurement, same clock
  input  wire logic [31:0] act_pos,
  input  wire logic [31:0] act_speed,
  // Cam outputs and interrupts
  output logic [7:0]       cam_out,
  output logic             pi1_pulse,
  output logic             pi2_pulse,
  output logic             irq
);
  import cto_pkg::*;

  cto_state_t s_r;
  cto_state_t s_nxt;

  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Wrapped range (start above end) models a rotary cam over the seam
  function automatic logic in_rng(input logic [31:0] p, input logic [31:0] a,
                                  input logic [31:0] b);
    logic r;
    if ($signed(a) <= $signed(b)) begin
      r = ($signed(p) >= $signed(a)) && ($signed(p) < $signed(b));
    end else begin
      r = ($signed(p) >= $signed(a)) || ($signed(p) < $signed(b));
    end
    return r;
  endfunction

  function automatic logic [16:0] tcam_ms(input logic [31:0] v);
    logic [16:0] d;
    d = v[16:0];
    if (v[31:16] != 16'h0000 || d > TCAM_MAX_MS) begin
      d = TCAM_MAX_MS;
    end
    d = (d + TCAM_STEP_M1) & ~TCAM_STEP_M1;
    if (d < TCAM_MIN_MS) begin
      d = TCAM_MIN_MS;
    end
    return d;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic              acc;
    logic              setup;
    logic              ms_tick;
    logic              recalc;
    logic signed [32:0] dspd;
    logic [32:0]       adiff;
    logic [31:0]       aused;
    logic [48:0]       prod;
    logic [32:0]       psum;
    logic [31:0]       pe;
    logic              fwd;
    logic              rev;
    logic              dir_ok;
    logic              ge;
    logic              trig;
    logic [7:0]        rise;
    logic [7:0]        fall;
    logic [2:0]        ev;
    logic [2:0]        w1c;
    logic [3:0]        i1;
    logic [3:0]        i2;
    logic [4:0]        ix;
    logic [31:0]       rd;
    logic              hit;

    s_nxt   = s_r;
    acc     = psel && penable && s_r.pready;
    setup   = psel && !penable;
    w1c     = 3'h0;
    ev      = 3'h0;
    rd      = 32'h0000_0000;
    hit     = 1'b1;
    ix      = 5'h00;
    ms_tick = 1'b0;
    recalc  = 1'b0;
    dspd    = 33'h0000_0000;
    adiff   = 33'h0000_0000;
    aused   = 32'h0000_0000;
    prod    = 49'h0000_0000_0000;
    psum    = 33'h0000_0000;
    pe      = 32'h0000_0000;
    fwd     = 1'b0;
    rev     = 1'b0;
    dir_ok  = 1'b1;
    ge      = 1'b0;
    trig    = 1'b0;
    rise    = 8'h00;
    fall    = 8'h00;
    i1      = 4'h0;
    i2      = 4'h0;

    // --------------------------------------------------------------
    // Register writes, taken at the access edge
    // --------------------------------------------------------------
    if (acc && pwrite) begin
      unique case (paddr)
        OFS_CTRL: begin
          s_nxt.tdyn  = pwdata[CTRL_TDYN_LSB +: 16];
          s_nxt.dmode = pwdata[CTRL_DMODE_LSB +: 2];
          s_nxt.ctype = pwdata[CTRL_CTYPE_LSB +: 2];
        end
        OFS_IRQCFG: begin
          s_nxt.sel1    = pwdata[IRQ_SEL1_LSB +: 4];
          s_nxt.edge1   = pwdata[IRQ_EDGE1_BIT];
          s_nxt.sel2    = pwdata[IRQ_SEL2_LSB +: 4];
          s_nxt.edge2   = pwdata[IRQ_EDGE2_BIT];
          s_nxt.toff_en = pwdata[IRQ_TOFF_BIT];
        end
        OFS_STATUS: w1c = pwdata[2:0];
        OFS_MASK:   s_nxt.msk = pwdata[2:0];
        default: begin
          if (paddr >= OFS_START0 && paddr <= OFS_TBL_TOP && paddr[1:0] == 2'h0) begin
            ix = 5'(paddr[6:2] - OFS_START0[6:2]);
            if (ix < 5'(NCAMS)) begin
              s_nxt.cstart[ix[2:0]] = pwdata;
            end else begin
              s_nxt.cend[ix[2:0]] = pwdata;
            end
          end
        end
      endcase
    end

    // --------------------------------------------------------------
    // Read data, latched in the setup cycle
    // --------------------------------------------------------------
    unique case (paddr)
      OFS_CTRL:   rd = {6'h00, s_r.ctype, 6'h00, s_r.dmode, s_r.tdyn};
      OFS_IRQCFG: rd = {15'h0000, s_r.toff_en, 3'h0, s_r.edge2, s_r.sel2,
                        3'h0, s_r.edge1, s_r.sel1};
      OFS_STATUS: rd = {29'h0000_0000, s_r.sts};
      OFS_MASK:   rd = {29'h0000_0000, s_r.msk};
      OFS_CAMST:  rd = {24'h00_0000, s_r.cam};
      OFS_OFFSET: rd = s_r.offs;
      default: begin
        if (paddr >= OFS_START0 && paddr <= OFS_TBL_TOP && paddr[1:0] == 2'h0) begin
          ix = 5'(paddr[6:2] - OFS_START0[6:2]);
          rd = (ix < 5'(NCAMS)) ? s_r.cstart[ix[2:0]] : s_r.cend[ix[2:0]];
        end else begin
          hit = 1'b0;
        end
      end
    endcase
    s_nxt.pready = setup;
    if (setup) begin
      s_nxt.prdata  = hit ? rd : 32'h0000_0000;
      s_nxt.pslverr = !hit;
    end

    // --------------------------------------------------------------
    // Millisecond base and dynamic offset
    // --------------------------------------------------------------
    ms_tick = (s_r.tick == MS_LAST);
    s_nxt.tick = ms_tick ? 16'h0000 : s_r.tick + 16'h0001;
    if (ms_tick) begin
      s_nxt.ms_cnt = s_r.ms_cnt + 8'h01;
    end

    dspd   = $signed({act_speed[31], act_speed}) - $signed({s_r.spd_used[31], s_r.spd_used});
    adiff  = dspd[32] ? 33'(-dspd) : 33'(dspd);
    aused  = s_r.spd_used[31] ? 32'(-s_r.spd_used) : s_r.spd_used;
    // Timeout fires when the 128th millisecond completes
    recalc = (adiff > {4'h0, aused[31:3]})
          || (ms_tick && s_r.ms_cnt == RECALC_MS - 8'h01);
    prod = 49'($signed(act_speed) * $signed({1'b0, s_r.tdyn}));
    if (recalc) begin
      s_nxt.spd_used = act_speed;
      s_nxt.ms_cnt   = 8'h00;
      // Large speed times time wraps; user keeps product inside 32 bits
      s_nxt.offs     = (s_r.tdyn == 16'h0000) ? 32'h0000_0000 : prod[31:0];
    end

    // Edges move against travel, same as looking ahead by the offset
    psum = {s_r.offs[31], s_r.offs} + {act_pos[31], act_pos};
    pe   = psum[31:0];

    fwd = !act_speed[31] && (act_speed != 32'h0000_0000);
    rev = act_speed[31];
    unique case (cto_dir_t'(s_r.dmode))
      CTO_DIR_FWD: dir_ok = !rev;
      CTO_DIR_REV: dir_ok = !fwd;
      default:     dir_ok = 1'b1;
    endcase

    // --------------------------------------------------------------
    // Cam switching
    // --------------------------------------------------------------
    for (int i = 0; i < NCAMS; i++) begin
      // Shifted test may drop a cam that the static test then restores
      s_nxt.cam[i] = dir_ok && (in_rng(pe, s_r.cstart[i], s_r.cend[i])
                     || in_rng(act_pos, s_r.cstart[i], s_r.cend[i]));
    end
    for (int i = 0; i < NTCAMS; i++) begin
      ge   = ($signed(pe) >= $signed(s_r.cstart[i]));
      trig = dir_ok && ((!s_r.ge_prev[i] && ge && fwd) || (s_r.ge_prev[i] && !ge && rev));
      s_nxt.ge_prev[i] = ge;
      if (!s_r.ctype[i]) begin
        s_nxt.tleft[i] = 17'h00000;
      end else if (trig) begin
        s_nxt.tleft[i] = tcam_ms(s_r.cend[i]);
      end else if (ms_tick && s_r.tleft[i] != 17'h00000) begin
        s_nxt.tleft[i] = s_r.tleft[i] - 17'h00001;
      end
      if (s_r.ctype[i]) begin
        s_nxt.cam[i] = (s_nxt.tleft[i] != 17'h00000);
        if (s_r.cam[i] && !s_nxt.cam[i] && s_r.toff_en) begin
          ev[ST_TOFF] = 1'b1;
        end
      end
    end

    // --------------------------------------------------------------
    // Process interrupts
    // --------------------------------------------------------------
    rise = s_nxt.cam & ~s_r.cam;
    fall = ~s_nxt.cam & s_r.cam;
    i1   = s_r.sel1 - 4'h1;
    i2   = s_r.sel2 - 4'h1;
    if (s_r.sel1 != 4'h0 && s_r.sel1 <= SEL_MAX) begin
      ev[ST_PI1] = s_r.edge1 ? rise[i1[2:0]] : fall[i1[2:0]];
    end
    if (s_r.sel2 != 4'h0 && s_r.sel2 <= SEL_MAX) begin
      ev[ST_PI2] = s_r.edge2 ? rise[i2[2:0]] : fall[i2[2:0]];
    end
    s_nxt.pi1 = ev[ST_PI1];
    s_nxt.pi2 = ev[ST_PI2];

    // New events win over a clear in the same cycle
    s_nxt.sts = (s_r.sts & ~w1c) | ev;
    s_nxt.irq = |(s_nxt.sts & s_nxt.msk);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r       <= '0;
      s_r.tdyn  <= TDYN_RST;
      s_r.dmode <= CTO_DIR_BOTH;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pready    = s_r.pready;
  assign prdata    = s_r.prdata;
  assign pslverr   = s_r.pslverr;
  assign cam_out   = s_r.cam;
  assign pi1_pulse = s_r.pi1;
  assign pi2_pulse = s_r.pi2;
  assign irq       = s_r.irq;

endmodule

// ==== testbench/cto_axis_model.sv ====
`timescale 1ns/1ps
// Axis measurement: position ramps by step, speed follows command
module cto_axis_model (
  input  wire logic        clk,
  input  wire logic        ld,
  input  wire logic [31:0] ld_pos,
  input  wire logic [31:0] step,
  input  wire logic [31:0] spd,
  output logic [31:0]      act_pos,
  output logic [31:0]      act_speed
);
  always_ff @(posedge clk) begin
    act_pos   <= ld ? ld_pos : act_pos + step;
    act_speed <= spd;
  end
endmodule

// ==== testbench/cto_track_checker.sv ====
`timescale 1ns/1ps
module cto_track_checker (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [7:0] cam_out,
  input wire logic       pi1_pulse,
  input wire logic       pi2_pulse,
  input wire logic       irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rdy; psel && !penable |=> pready; endproperty
  property p_rdy1; pready |=> !pready; endproperty
  property p_pi1; pi1_pulse |=> !pi1_pulse; endproperty
  property p_pi2; pi2_pulse |=> !pi2_pulse; endproperty
  property p_cause1; pi1_pulse |-> cam_out != $past(cam_out); endproperty
  property p_cause2; pi2_pulse |-> cam_out != $past(cam_out); endproperty
  property p_rst; $fell(rst) |-> cam_out == 8'h00 && !irq && !pi1_pulse; endproperty
  // Irq may only drop through a register write
  property p_irqf;
    $fell(irq) |-> $past(pwrite && penable) || $past(pwrite && penable, 2);
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  a_rdy1: assert property (p_rdy1) else $error("ready too long");
  a_pi1: assert property (p_pi1) else $error("pi1 pulse too long");
  a_pi2: assert property (p_pi2) else $error("pi2 pulse too long");
  a_cause1: assert property (p_cause1) else $error("pi1 without edge");
  a_cause2: assert property (p_cause2) else $error("pi2 without edge");
  a_rst: assert property (p_rst) else $error("outputs not idle");
  a_irqf: assert property (p_irqf) else $error("irq dropped alone");
  cover property (pi1_pulse);
  cover property (pi2_pulse);
  cover property (irq);
  cover property (pslverr);
endmodule
bind cto_track cto_track_checker chk (.*);

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import cto_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, ld = 1;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, ld_pos = 0, step = 0, spd = 0;
  logic pready, pslverr, pi1_pulse, pi2_pulse, irq, e1, e2, ed1, ed2;
  logic [31:0] prdata, act_pos, act_speed, rdat, rerr;
  logic [7:0] cam_out;
  logic [3:0] s1, s2, m;
  int n_mismatch = 0, checks = 0, n1, n2, hi, v, t;
  int st[8], ln[8];
  always #20 clk = ~clk;
  cto_axis_model pm (.clk(clk), .ld(ld), .ld_pos(ld_pos), .step(step), .spd(spd),
    .act_pos(act_pos), .act_speed(act_speed));
  cto_track #(.MS_CYCLES(10)) uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .act_pos(act_pos), .act_speed(act_speed), .cam_out(cam_out),
    .pi1_pulse(pi1_pulse), .pi2_pulse(pi2_pulse), .irq(irq));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = 32'(pslverr);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  function automatic logic [7:0] cams(input int p);
    for (int i = 0; i < 8; i++) cams[i] = p >= st[i] && p < st[i] + ln[i];
  endfunction
  // Hold each position long enough to stay clear of the sample latency
  task automatic go(input int p, input int n);
    ld <= 1'b1; ld_pos <= p;
    @(posedge clk) ld <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (pi1_pulse === 1'b1) begin n1++; ed1 = cam_out[(s1 + 7) % 8]; end
    if (pi2_pulse === 1'b1) begin n2++; ed2 = cam_out[(s2 + 7) % 8]; end
    if (cam_out[0] === 1'b1) hi++;
  end
  initial begin repeat (40000) @(posedge clk); n_mismatch++; wrap_up(); end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hdf436066));
    for (int i = 0; i < 8; i++) begin st[i] = -400 + 200 * i; ln[i] = $urandom_range(20, 150); end
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_CTRL, 32'h0);
    rd(OFS_IRQCFG, 32'h0);
    rd(8'h18, 32'h0);
    chk(rerr, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h0000ffff);
    rd(OFS_CTRL, 32'h0000ffff);
    apb(1'b1, OFS_CTRL, 32'h0);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFS_START0 + 8'(4 * i), st[i]);
      apb(1'b1, OFS_END0 + 8'(4 * i), st[i] + ln[i]);
    end
    for (int s = 0; s < 9; s++) begin
      s1 = 4'(s); s2 = 4'(8 - s); e1 = 1'($urandom); e2 = 1'($urandom);
      m = 4'($urandom_range(0, 3));
      apb(1'b1, OFS_IRQCFG, {19'h0, e2, s2, 3'h0, e1, s1});
      apb(1'b1, OFS_MASK, 32'(m));
      n1 = 0; n2 = 0;
      for (int p = -600; p < 1400; p += 10) begin
        go(p, 3);
        chk(32'(cam_out), 32'(cams(p)));
      end
      chk(n1, 32'(s1 != 0));
      chk(n2, 32'(s2 != 0));
      if (s1 != 0) chk(32'(ed1), 32'(e1));
      if (s2 != 0) chk(32'(ed2), 32'(e2));
      chk(32'(irq), 32'(|(m[1:0] & {s2 != 0, s1 != 0})));
      rd(OFS_STATUS, {30'h0, s2 != 0, s1 != 0});
      apb(1'b1, OFS_STATUS, 32'h7);
      chk(32'(irq), 32'h0);
    end
    s1 = 4'h9;
    apb(1'b1, OFS_IRQCFG, 32'h0000_0019);
    n1 = 0;
    go(st[0] + 5, 3);
    chk(n1, 32'h0);
    t = $urandom_range(1, 9); v = $urandom_range(16, 40);
    apb(1'b1, OFS_CTRL, 32'(t));
    spd <= v;
    repeat (20) @(posedge clk);
    rd(OFS_OFFSET, v * t);
    spd <= v + 1;
    repeat (3) @(posedge clk);
    rd(OFS_OFFSET, v * t);
    repeat (1300) @(posedge clk);
    rd(OFS_OFFSET, (v + 1) * t);
    go(st[2] + ln[2] - 1, 4);
    chk(32'(cam_out[2]), 32'h1);
    go(st[2] + 5 - (v + 1) * t, 4);
    chk(32'(cam_out[2]), 32'h1);
    apb(1'b1, OFS_CTRL, 32'h0);
    spd <= 3 * v;
    repeat (20) @(posedge clk);
    rd(OFS_OFFSET, 32'h0);
    chk(32'(cam_out[2]), 32'h0);
    apb(1'b1, OFS_CTRL, 32'h00010000);
    go(st[3] + 5, 4);
    spd <= -8;
    repeat (5) @(posedge clk);
    chk(32'(cam_out[3]), 32'h0);
    spd <= 8;
    repeat (5) @(posedge clk);
    chk(32'(cam_out[3]), 32'h1);
    rd(OFS_CAMST, 32'(cams(st[3] + 5)));
    apb(1'b1, OFS_CTRL, 32'h00020000);
    repeat (5) @(posedge clk);
    chk(32'(cam_out[3]), 32'h0);
    spd <= -8;
    repeat (5) @(posedge clk);
    chk(32'(cam_out[3]), 32'h1);
    spd <= 8;
    apb(1'b1, OFS_CTRL, 32'hfd000000);
    rd(OFS_CTRL, 32'h01000000);
    apb(1'b1, OFS_END0, 32'd20);
    apb(1'b1, OFS_IRQCFG, 32'h00010000);
    apb(1'b1, OFS_MASK, 32'h4);
    apb(1'b1, OFS_STATUS, 32'h7);
    go(st[0] - 10, 2);
    hi = 0;
    step <= 32'h1;
    repeat (500) @(posedge clk);
    step <= 32'h0;
    chk(32'(hi >= 230 && hi <= 250), 32'h1);
    rd(OFS_STATUS, 32'h4);
    chk(32'(irq), 32'h1);
    wrap_up();
  end
endmodule
